// >>> dv/adc_ctrl_sva.sv
// Purpose: Port-level checks of the converter control block.
// Assumes: hready is looped back from hreadyout.
// Notes:   Cycle figures follow the agreed sequencer timing.
module adc_ctrl_sva
	import adc_ctrl_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        track_hold,
	input wire logic        busy_n,
	input wire logic        almost_full_flag_n,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	logic tk;
	logic wr_dp_q;
	logic wr_cm_q;
	logic mk_dp_q;
	assign tk = hsel && htrans == HTRANS_NONSEQ && hready;

	// Track write data phases so commits are not mistaken for side effects
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_dp_q <= 1'b0;
			mk_dp_q <= 1'b0;
		end else if (hready) begin
			wr_dp_q <= tk && hwrite;
			mk_dp_q <= tk && hwrite && haddr == A_IMASK;
		end
	end

	// A commit one edge back still moves the flag at the next edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_cm_q <= 1'b0;
		end else begin
			wr_cm_q <= wr_dp_q && hready;
		end
	end

	property p_rst_out;
		$rose(nrst) |-> almost_full_flag_n && busy_n && !track_hold && !irq;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not idle after reset");
	property p_hold;
		$rose(track_hold) |-> !busy_n ##19 !busy_n ##1 busy_n;
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold settle length wrong");
	property p_conv;
		$rose(track_hold) |-> ##279 track_hold ##1 !track_hold;
	endproperty
	a_conv: assert property (p_conv)
		else $error("conversion length wrong");
	property p_flag_end;
		$fell(almost_full_flag_n) |-> $fell(track_hold);
	endproperty
	a_flag_end: assert property (p_flag_end)
		else $error("flag asserted outside conversion end");
	property p_rd_ans;
		tk && !hwrite |=> ##[0:22] hreadyout;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read not answered");
	property p_wr_rdy;
		tk && hwrite |=> hreadyout;
	endproperty
	a_wr_rdy: assert property (p_wr_rdy)
		else $error("write stalled");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("error response");
	property p_scr_quiet;
		tk && !hwrite && haddr == A_SCR && !track_hold && !wr_dp_q &&
			!wr_cm_q
			|=> $stable(almost_full_flag_n);
	endproperty
	a_scr_quiet: assert property (p_scr_quiet)
		else $error("status read moved the flag");
	property p_irq_off;
		mk_dp_q && hready && hwdata[IRQ_W-1:0] == 3'h0 |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("masked interrupt still high");
endmodule : adc_ctrl_sva

bind adc_ctrl adc_ctrl_sva i_sva (.sys_clk, .nrst, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .track_hold,
	.busy_n, .almost_full_flag_n, .irq);

// >>> dv/adc_ctrl_tb_top.sv
// Purpose: Self-checking bench of the converter control block.
// Assumes: One bus master; hready looped back from hreadyout.
// Notes:   Read data is scored by a monitor against queued notes.
module adc_ctrl_tb_top
	import adc_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic              sys_clk = 1'b0;
	logic              nrst = 1'b0;
	logic              hsel = 1'b0;
	logic              hwrite = 1'b0;
	logic              sample_start = 1'b0;
	logic              rdy_n = 1'b1;
	logic              rd_pend = 1'b0;
	logic [1:0]        htrans = 2'h0;
	logic [31:0]       haddr = 32'h0000_0000;
	logic [31:0]       hwdata = 32'h0000_0000;
	logic [31:0]       hrdata, rd_n;
	logic [DATA_W-1:0] sar_result;
	logic              sar_overrange, hreadyout, hresp, irq;
	logic              track_hold, busy_n, almost_full_flag_n;
	logic [WORD_W-1:0] next_word = 13'h0000;
	logic [WORD_W-1:0] fifo_m[$];
	logic [31:0]       exp_q[$], msk_q[$];
	logic              flag_e = 1'b1, dis_e = 1'b0, ovr_e = 1'b0;
	logic              oor_e = 1'b0, ist_e = 1'b0, msk_e = 1'b0;
	logic [2:0]        thr_e = 3'h0;
	int                n_errors = 0, total_checks = 0;

	always #5 sys_clk = ~sys_clk;

	adc_ctrl i_dut (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .sample_start, .sar_result, .sar_overrange, .track_hold,
		.busy_n, .almost_full_flag_n, .irq);
	sar_core_model i_core (.sys_clk, .track_hold, .next_word,
		.sar_result, .sar_overrange);

	// Bus answers settle mid-cycle; this copy is what the edge sees
	always @(negedge sys_clk) begin
		rdy_n = hreadyout;
		rd_n = hrdata;
	end

	task automatic fail(input string m);
		n_errors++;
		$display("ERROR %0t %s", $time, m);
	endtask : fail

	task automatic check_rd(input logic [31:0] got);
		logic [31:0] e;
		logic [31:0] m;
		total_checks++;
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		if ((got & m) !== (e & m))
			fail("read data mismatch");
	endtask : check_rd

	task automatic check_pin(input logic got, input logic e);
		total_checks++;
		if (got !== e)
			fail("output pin mismatch");
	endtask : check_pin

	// Scores each read when its data phase ends
	always @(posedge sys_clk) begin
		if (rd_pend && rdy_n)
			check_rd(rd_n);
		if (rdy_n)
			rd_pend = hsel && htrans == HTRANS_NONSEQ && !hwrite;
	end

	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge sys_clk); while (rdy_n !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge sys_clk); while (rdy_n !== 1'b1);
	endtask : bus

	task automatic rd(input logic [31:0] a, input logic [31:0] e,
		input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(a, 1'b0, 32'h0000_0000);
	endtask : rd

	function automatic logic [31:0] scr();
		int k;
		k = fifo_m.size();
		return {20'h0_0000, flag_e, thr_e, dis_e, ovr_e, oor_e, k == 0,
			k > 0 && fifo_m[0][OOR_BIT], k > 1 ? 3'(k - 1) : 3'h0};
	endfunction : scr

	task automatic pins(input logic f, input logic i);
		@(negedge sys_clk);
		check_pin(almost_full_flag_n, f);
		check_pin(irq, i);
		@(posedge sys_clk);
	endtask : pins

	// Sets the output-enable bit, so reads are served even during hold
	task automatic wscr(input logic [2:0] t, input logic d);
		thr_e = t;
		dis_e = d;
		if (d)
			flag_e = 1'b1;
		bus(A_SCR, 1'b1, {20'h0_0000, 1'b0, t, d, 2'b01, 5'h00});
	endtask : wscr

	task automatic convert(input bit b);
		int i;
		next_word <= 13'($urandom);
		repeat ($urandom_range(3)) @(posedge sys_clk);
		sample_start <= 1'b1;
		i = 0;
		while (track_hold !== 1'b1 && i < 9) begin
			@(negedge sys_clk);
			i++;
		end
		if (i >= 9)
			fail("start edge ignored");
		@(posedge sys_clk);
		sample_start <= 1'b0;
		if (b)
			rd(A_SCR, scr(), ALL);
		while (track_hold !== 1'b0 && i < 400) begin
			@(negedge sys_clk);
			i++;
		end
		@(posedge sys_clk);
		if (i >= 400)
			fail("conversion never ended");
		ist_e = 1'b1;
		if (fifo_m.size() < DEPTH) begin
			fifo_m.push_back(next_word);
			oor_e |= next_word[OOR_BIT];
		end else
			ovr_e = 1'b1;
		flag_e = dis_e || fifo_m.size() < thr_e + 1;
	endtask : convert

	task automatic pop();
		logic [WORD_W-1:0] w;
		rd(A_SCR, scr(), ALL);
		w = fifo_m.pop_front();
		if (fifo_m.size() < thr_e + 1)
			flag_e = 1'b1;
		if (fifo_m.size() == 0)
			oor_e = 1'b0;
		rd(A_FIFO, {20'h0_0000, w[DATA_W-1:0]}, ALL);
	endtask : pop

	task automatic final_report();
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	initial begin
		#400_000;
		fail("watchdog expired");
		final_report();
	end

	initial begin
		int n;
		void'($urandom(94088));
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rd(A_SCR, 32'h0000_0810, ALL);
		rd(A_FIFO, 32'h0000_0800, ALL);
		bus(32'h0000_0010, 1'b1, ALL);
		rd(32'h0000_0010, 32'h0000_0000, ALL);
		rd(A_IMASK, 32'h0000_0000, ALL);
		// Overfill with gating on; the first status read stalls in hold
		for (n = 0; n < 9; n++)
			convert(n == 0);
		rd(A_SCR, scr(), ALL);
		rd(A_ISTAT, 32'h0000_0005, 32'h0000_0005);
		ist_e = 1'b0;
		bus(A_SCR, 1'b1, 32'h0000_0040);
		fifo_m.delete();
		{flag_e, thr_e, dis_e, ovr_e, oor_e} = {1'b1, 3'h0, 3'h0};
		rd(A_SCR, 32'h0000_0810, ALL);
		rd(A_FIFO, 32'h0000_0800, ALL);
		// Interrupt raised, masked, unmasked and cleared by reading
		bus(A_IMASK, 1'b1, 32'h0000_0001);
		msk_e = 1'b1;
		convert(1'b0);
		pins(flag_e, 1'b1);
		bus(A_IMASK, 1'b1, 32'h0000_0000);
		pins(flag_e, 1'b0);
		bus(A_IMASK, 1'b1, 32'h0000_0001);
		pins(flag_e, 1'b1);
		rd(A_ISTAT, 32'h0000_0001, 32'h0000_0001);
		ist_e = 1'b0;
		pins(flag_e, 1'b0);
		pop();
		// Every threshold from one to eight stored words
		for (n = 0; n < 8; n++) begin
			wscr(3'(n), 1'b0);
			repeat (n + 1) begin
				convert(n == 3);
				pins(flag_e, ist_e & msk_e);
			end
			rd(A_SCR, scr(), ALL);
			rd(A_SCR, scr(), ALL);
			while (fifo_m.size() > 0) begin
				pop();
				pins(flag_e, ist_e & msk_e);
			end
		end
		wscr(3'h0, 1'b1);
		convert(1'b0);
		pins(1'b1, 1'b1);
		rd(A_SCR, scr(), ALL);
		pop();
		repeat (4) @(posedge sys_clk);
		final_report();
	end
endmodule : adc_ctrl_tb_top

// >>> dv/sar_core_model.sv
// Purpose: Behavioural converter core feeding results to the block.
// Assumes: The block samples the result while track_hold is high.
// Notes:   Outside a conversion the lines toggle, so stale reads show.
module sar_core_model
	import adc_ctrl_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              track_hold,
	input  wire logic [WORD_W-1:0] next_word,
	output logic      [DATA_W-1:0] sar_result,
	output logic                   sar_overrange
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WORD_W-1:0] held_q = 13'h0000;
	logic              th_q = 1'b0;

	// Latch the sample as hold begins, keep it while hold stays high, scramble it while low
	always @(posedge sys_clk) begin
		th_q <= track_hold;
		if (track_hold && !th_q)
			held_q <= next_word;
		else if (!track_hold)
			held_q <= ~held_q;
	end
	assign {sar_overrange, sar_result} = held_q;
endmodule : sar_core_model

// >>> hdl/adc_ctrl.sv
// Purpose: Sequencing, result FIFO control and status/control register
//          of a sampling converter, reached over AHB-Lite.
// Assumes: Converter core hands sar_result and sar_overrange on sys_clk.
// Notes:   hready must be this slave's hreadyout; only word transfers.
// What this block does
// - Rising sample_start puts track/hold into hold and starts conversion.
// - sample_start is asynchronous and ignores select and bus strobes.
// - Reset loads FIFO words 0x800, raises flag, resets control register.
// - All sequencing runs from the clock; duty ratio 35/65..65/35 is fine.
// - Register-select access moves register contents over data_lines.
// - Register write sets flag behaviour, bus behaviour, FIFO reset.
// - Pointer increments per conversion and compares with threshold.
// - Flag asserts at threshold only while almost_full_disable is zero.
// - Threshold lets the flag fire after 1 to 8 stored results.
// - Pointer, overrange and flag status readable anytime; with diso_q clear, reads wait out hold settle.
// - Status reads never move FIFO words nor change the pointer.
// - Flag is active low, updated at conversion end, released on read.
// - almost_full_disable at bit 7 disables flag pin and status bit.
// - threshold_count is read/write bits 10..8, MSB first.
// - FIFO read returns word 0, words shift down, pointer decrements.
module adc_ctrl
	import adc_ctrl_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic      [31:0]       hrdata,
	input  wire logic              sample_start,
	input  wire logic [DATA_W-1:0] sar_result,
	input  wire logic              sar_overrange,
	output logic                   track_hold,
	output logic                   busy_n,
	output logic                   almost_full_flag_n,
	output logic                   irq
);

	// Conversion sequencer state
	conv_state_t       state_q;
	logic [TMR_W-1:0]  tmr_q;
	logic              start_rise;
	logic              conv_done;

	// FIFO bookkeeping
	logic [CNT_W-1:0]  count_q;
	logic [CNT_W-1:0]  count_d;
	logic [WORD_W-1:0] bottom_q;
	logic              push;
	logic              pop;
	logic              overrun;
	logic              ovr_q;
	logic              oor_q;
	logic              af_n_q;
	logic              af_n_d;

	// Control fields of the status/control register
	logic [THR_W-1:0]  thr_q;
	logic              dis_q;
	logic              diso_q;

	// Bus phases
	logic              take;
	logic              rd_ph_q;
	logic              wr_ph_q;
	logic              rd_ok_q;
	logic [31:0]       ph_addr_q;
	logic              rd_stall;
	logic              rd_go;
	logic [31:0]       rd_val;
	logic              scr_wr;
	logic              soft_rst;
	logic              mask_wr;
	logic              istat_rd;
	logic              fifo_rd;

	// Interrupt registers
	logic [IRQ_W-1:0]  istat_q;
	logic [IRQ_W-1:0]  imask_q;
	logic [IRQ_W-1:0]  irq_ev;

	// Word count as shown in the low three status bits
	function automatic logic [2:0] cnt_field(input logic [CNT_W-1:0] w);
		cnt_field = (w == 4'h0) ? 3'h0 : 3'(w - 4'h1);
	endfunction : cnt_field

	// Code n means the flag fires when n+1 words are held
	function automatic logic reached(input logic [CNT_W-1:0] w,
		input logic [THR_W-1:0] t);
		reached = w > {1'b0, t};
	endfunction : reached

	// Start pin is sampled on its own, never gated by the bus
	edge_sync u_start_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.pin_in  (sample_start),
		.level_q (),
		.rise    (start_rise)
	);

	// Converter sequence: hold settle, then conversion, all on sys_clk
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= CV_IDLE;
			tmr_q   <= '0;
		end else if (soft_rst) begin
			state_q <= CV_IDLE;
			tmr_q   <= '0;
		end else begin
			case (state_q)
				CV_IDLE: begin
					if (start_rise) begin
						state_q <= CV_HOLD;
						tmr_q   <= TMR_W'(HOLD_CYC - 1);
					end
				end
				CV_HOLD: begin
					if (tmr_q == '0) begin
						state_q <= CV_CONV;
						tmr_q   <= TMR_W'(CONV_CYC - 1);
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				CV_CONV: begin
					if (tmr_q == '0) begin
						state_q <= CV_IDLE;
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				default: begin
					state_q <= CV_IDLE;
				end
			endcase
		end
	end

	assign conv_done = (state_q == CV_CONV) && (tmr_q == '0);

	// Pin outputs from flops; edges arriving mid-conversion are dropped
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			track_hold <= 1'b0;
			busy_n     <= 1'b1;
		end else if (soft_rst) begin
			track_hold <= 1'b0;
			busy_n     <= 1'b1;
		end else begin
			track_hold <= (state_q == CV_IDLE) ? start_rise :
				!conv_done;
			busy_n <= (state_q == CV_IDLE) ? !start_rise :
				!(state_q == CV_HOLD && tmr_q != '0);
		end
	end

	// FIFO moves: push at conversion end, pop only on a data read
	assign pop     = fifo_rd && (count_q != '0);
	assign push    = conv_done &&
		((count_q != CNT_W'(DEPTH)) || pop);
	assign overrun = conv_done && !push;

	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 4'h1;
		end else if (pop && !push) begin
			count_d = count_q - 4'h1;
		end
	end

	fifo_shift_mem u_mem (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.clear    (soft_rst),
		.push     (push),
		.pop      (pop),
		.count    (count_q),
		.wr_word  ({sar_overrange, sar_result}),
		.bottom_q (bottom_q)
	);

	// Pointer and sticky FIFO status; status reads never touch them
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= '0;
			ovr_q   <= 1'b0;
			oor_q   <= 1'b0;
		end else if (soft_rst) begin
			count_q <= '0;
			ovr_q   <= 1'b0;
			oor_q   <= 1'b0;
		end else begin
			count_q <= count_d;
			ovr_q   <= ovr_q || overrun;
			if (push && sar_overrange) begin
				oor_q <= 1'b1;
			end else if (count_d == '0) begin
				oor_q <= 1'b0;
			end
		end
	end

	// Flag: compare at conversion end, release on read below threshold
	always_comb begin
		af_n_d = af_n_q;
		if (dis_q) begin
			af_n_d = 1'b1;
		end else if (conv_done) begin
			af_n_d = !reached(count_d, thr_q);
		end else if (pop && !reached(count_d, thr_q)) begin
			af_n_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			af_n_q <= 1'b1;
		end else if (soft_rst) begin
			af_n_q <= 1'b1;
		end else begin
			af_n_q <= af_n_d;
		end
	end

	assign almost_full_flag_n = af_n_q;

	// Control fields; the reset bit acts without being stored
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			thr_q  <= THR_RST;
			dis_q  <= DIS_RST;
			diso_q <= DISO_RST;
		end else if (soft_rst) begin
			thr_q  <= THR_RST;
			dis_q  <= DIS_RST;
			diso_q <= DISO_RST;
		end else if (scr_wr) begin
			thr_q  <= hwdata[B_THR_HI:B_THR_LO];
			dis_q  <= hwdata[B_DIS];
			diso_q <= hwdata[B_OOR];
		end
	end

	// Address phase; a new one is only taken while hready is high
	assign take = hsel && (htrans == HTRANS_NONSEQ) && hready;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_ph_q   <= 1'b0;
			wr_ph_q   <= 1'b0;
			ph_addr_q <= '0;
		end else if (hready) begin
			rd_ph_q <= take && !hwrite;
			wr_ph_q <= take && hwrite;
			if (take) begin
				ph_addr_q <= haddr;
			end
		end
	end

	// Reads wait while busy unless outputs are allowed then
	assign rd_stall  = !diso_q && !busy_n;
	assign rd_go     = rd_ph_q && !rd_ok_q && !rd_stall;
	assign hreadyout = !(rd_ph_q && !rd_ok_q);
	assign hresp     = 1'b0;

	// Side effects of the data phase
	assign scr_wr   = wr_ph_q && hready && (ph_addr_q == A_SCR);
	assign soft_rst = scr_wr && hwdata[B_OVR];
	assign mask_wr  = wr_ph_q && hready && (ph_addr_q == A_IMASK);
	assign istat_rd = rd_go && (ph_addr_q == A_ISTAT);
	assign fifo_rd  = rd_go && (ph_addr_q == A_FIFO);

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_val = '0;
		case (ph_addr_q)
			A_FIFO: begin
				rd_val[DATA_W-1:0] = bottom_q[DATA_W-1:0];
			end
			A_SCR: begin
				rd_val[B_AF]              = af_n_q;
				rd_val[B_THR_HI:B_THR_LO] = thr_q;
				rd_val[B_DIS]             = dis_q;
				rd_val[B_OVR]             = ovr_q;
				rd_val[B_OOR]             = oor_q;
				rd_val[B_EMP]             = (count_q == '0);
				rd_val[B_SOOR]            = bottom_q[OOR_BIT];
				rd_val[B_CNT_HI:0]        = cnt_field(count_q);
			end
			A_ISTAT: begin
				rd_val[IRQ_W-1:0] = istat_q;
			end
			A_IMASK: begin
				rd_val[IRQ_W-1:0] = imask_q;
			end
			default: begin
				rd_val = '0;
			end
		endcase
	end

	// Read data held in a flop until the next read is served
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_ok_q <= 1'b0;
			hrdata  <= '0;
		end else if (rd_go) begin
			rd_ok_q <= 1'b1;
			hrdata  <= rd_val;
		end else if (hready) begin
			rd_ok_q <= 1'b0;
		end
	end

	// Interrupt events: result stored, flag asserted, result lost
	assign irq_ev[IRQ_DONE] = push;
	assign irq_ev[IRQ_AF]   = af_n_q && !af_n_d;
	assign irq_ev[IRQ_OVR]  = overrun;

	// Sticky status; a new event beats the clear of the same read
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			istat_q <= '0;
		end else begin
			istat_q <= (istat_rd ? '0 : istat_q) | irq_ev;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			imask_q <= '0;
		end else if (mask_wr) begin
			imask_q <= hwdata[IRQ_W-1:0];
		end
	end

	assign irq = |(istat_q & imask_q);

endmodule : adc_ctrl

// >>> hdl/adc_ctrl_pkg.sv
// Purpose: Shared constants and types of the converter control block.
// Assumes: One 100 MHz clock; AHB-Lite register access, word transfers.
// Notes:   Times are in ns; cycle counts are derived from them.
package adc_ctrl_pkg;

	// Clock and conversion timing
	localparam int unsigned CLK_MHZ    = 100;
	localparam int unsigned T_HOLD_NS  = 200;
	localparam int unsigned T_CONV_NS  = 2600;
	localparam int unsigned HOLD_CYC   = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CONV_CYC   = (T_CONV_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TMR_W      = 9;

	// Result FIFO shape
	localparam int unsigned DATA_W     = 12;
	localparam int unsigned WORD_W     = 13;
	localparam int unsigned DEPTH      = 8;
	localparam int unsigned CNT_W      = 4;
	localparam int unsigned OOR_BIT    = 12;
	localparam logic [WORD_W-1:0] FIFO_INIT = 13'h0800;

	// Register byte addresses
	localparam logic [31:0] A_FIFO     = 32'h0000_0000;
	localparam logic [31:0] A_SCR      = 32'h0000_0004;
	localparam logic [31:0] A_ISTAT    = 32'h0000_0008;
	localparam logic [31:0] A_IMASK    = 32'h0000_000C;

	// Status/control field positions
	localparam int unsigned B_AF       = 11;
	localparam int unsigned B_THR_HI   = 10;
	localparam int unsigned B_THR_LO   = 8;
	localparam int unsigned B_DIS      = 7;
	localparam int unsigned B_OVR      = 6;
	localparam int unsigned B_OOR      = 5;
	localparam int unsigned B_EMP      = 4;
	localparam int unsigned B_SOOR     = 3;
	localparam int unsigned B_CNT_HI   = 2;
	localparam int unsigned THR_W      = 3;

	// Reset values of the control fields
	localparam logic [THR_W-1:0] THR_RST  = 3'h0;
	localparam logic             DIS_RST  = 1'b0;
	localparam logic             DISO_RST = 1'b0;

	// Interrupt status bits
	localparam int unsigned IRQ_DONE   = 0;
	localparam int unsigned IRQ_AF     = 1;
	localparam int unsigned IRQ_OVR    = 2;
	localparam int unsigned IRQ_W      = 3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		CV_IDLE,
		CV_HOLD,
		CV_CONV
	} conv_state_t;

endpackage : adc_ctrl_pkg

// >>> hdl/edge_sync.sv
// Purpose: Brings an asynchronous pin into sys_clk and flags rising edges.
// Assumes: Input may change at any moment relative to the clock.
// Notes:   A change counts once the second and third stages agree.
module edge_sync (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic pin_in,
	output logic      level_q,
	output logic      rise
);

	logic [2:0] stage_q;

	// Three-stage chain; stage 0 feeds only stage 1
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stage_q <= 3'h0;
		end else begin
			stage_q <= {stage_q[1:0], pin_in};
		end
	end

	// Accepted level moves only on agreement, filtering one-cycle glitches
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			level_q <= 1'b0;
		end else if (stage_q[1] == stage_q[2]) begin
			level_q <= stage_q[2];
		end
	end

	assign rise = (stage_q[1] == stage_q[2]) && stage_q[2] && !level_q;

endmodule : edge_sync

// >>> hdl/fifo_shift_mem.sv
// Purpose: Eight-word shift-down result store with the oldest word at 0.
// Assumes: Caller never pops when empty nor pushes when full without pop.
// Notes:   Word 0 is a flop, so read data always comes from a register.
module fifo_shift_mem
	import adc_ctrl_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              clear,
	input  wire logic              push,
	input  wire logic              pop,
	input  wire logic [CNT_W-1:0]  count,
	input  wire logic [WORD_W-1:0] wr_word,
	output logic      [WORD_W-1:0] bottom_q
);

	logic [WORD_W-1:0] mem_q [DEPTH];
	logic [CNT_W-1:0]  wr_idx;

	// New word lands just above the survivors of a same-cycle pop
	assign wr_idx = pop ? count - 4'h1 : count;

	// Reset and clear load the idle pattern into every word
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= FIFO_INIT;
			end
		end else if (clear) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= FIFO_INIT;
			end
		end else begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				if (push && wr_idx == CNT_W'(i)) begin
					mem_q[i] <= wr_word;
				end else if (pop) begin
					mem_q[i] <= mem_q[i+1];
				end
			end
			if (push && wr_idx == CNT_W'(DEPTH - 1)) begin
				mem_q[DEPTH-1] <= wr_word;
			end
		end
	end

	assign bottom_q = mem_q[0];

endmodule : fifo_shift_mem
